// >>> core/alu_unit.sv
`timescale 1ns/10ps
`default_nettype none
module alu_unit
  import core_pkg::*;
(
  input  wire alu_op_e    op,        // operation
  input  wire logic [7:0] a,         // first operand
  input  wire logic [7:0] b,         // second operand
  input  wire logic       carry_in,  // incoming carry
  input  wire logic       decimal,   // packed decimal mode
  output logic      [7:0] result,    // result byte
  output logic            carry_out, // carry / not borrow
  output logic            overflow,  // signed overflow
  output logic            negative,  // result bit seven, operand b bit seven for bit test
  output logic            zero       // result is zero
);

  logic [8:0] sum9;
  logic [8:0] dif9;
  logic [4:0] lo5;
  logic [4:0] hi5;

  always_comb begin
    sum9      = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
    dif9      = {1'b0, a} - {1'b0, b} - {8'h00, ~carry_in};
    lo5       = 5'h00;
    hi5       = 5'h00;
    result    = a;
    carry_out = carry_in;
    overflow  = 1'b0;
    case (op)
      ALU_ADD: begin
        result    = sum9[7:0];                             // see [RULE17]
        carry_out = sum9[8];                               // see [RULE17]
        overflow  = (a[7] == b[7]) && (sum9[7] != a[7]);
        if (decimal) begin
          lo5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carry_in};
          if (lo5 > BCD_LIMIT) begin
            lo5 = lo5 + BCD_FIX;                           // see [RULE2]
          end
          hi5 = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo5[4]};
          carry_out = 1'b0;
          if (hi5 > BCD_LIMIT) begin
            hi5       = hi5 + BCD_FIX;                     // see [RULE2]
            carry_out = 1'b1;
          end
          result = {hi5[3:0], lo5[3:0]};
        end
      end
      ALU_SUB: begin
        result    = dif9[7:0];
        carry_out = ~dif9[8];
        overflow  = (a[7] != b[7]) && (dif9[7] != a[7]);
        if (decimal) begin
          lo5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~carry_in};
          if (lo5[4]) begin
            lo5 = lo5 - BCD_FIX;                           // see [RULE2]
          end
          hi5 = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo5[4]};
          if (hi5[4]) begin
            hi5 = hi5 - BCD_FIX;                           // see [RULE2]
          end
          result = {hi5[3:0], lo5[3:0]};
        end
      end
      // compares are always binary and never borrow in
      ALU_CMP: begin
        result    = a - b;
        carry_out = (a >= b);
      end
      ALU_INC: result = a + 8'h01;
      ALU_DEC: result = a - 8'h01;
      ALU_ASL: begin
        result    = {a[6:0], 1'b0};                        // see [RULE19]
        carry_out = a[7];                                  // see [RULE19]
      end
      ALU_AND: result = a & b;
      ALU_BIT: begin
        result   = a & b;                                  // see [RULE18]
        overflow = b[6];                                   // see [RULE18]
      end
      ALU_PASS: result = b;
      default:  result = a;
    endcase
    negative = (op == ALU_BIT) ? b[7] : result[7];         // see [RULE18]
    zero     = (result == 8'h00);
  end

endmodule
`default_nettype wire

// >>> core/cpu_core.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_core
  import core_pkg::*;
#(
  parameter logic [15:0] RESET_ADDR = RESET_PC  // first fetch address
)
(
  input  wire logic       clock,      // system clock
  input  wire logic       rst_n,      // async reset, active low
  input  wire logic [7:0] mem_rdata,  // read data, valid while mem_req.rd
  output mem_req_s        mem_req,    // registered bus request
  output core_view_s      core_view,  // registered programmer state
  output logic            irq_enable, // maskable interrupts accepted
  output logic            cycle_end   // last clock of a core cycle
);

  // ==========================================================
  // state
  core_state_e state_q, state_d;
  logic        phase_q, phase_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  a_q, a_d;
  logic [7:0]  x_q, x_d;
  logic [7:0]  y_q, y_d;
  logic [7:0]  sp_q, sp_d;
  status_s     p_q, p_d;
  logic [7:0]  opcode_q, opcode_d;
  logic [7:0]  addr_lo_q, addr_lo_d;
  logic [7:0]  addr_hi_q, addr_hi_d;
  logic [7:0]  result_q, result_d;
  mem_req_s    bus_q, bus_d;

  logic [7:0]  op_now;
  op_class_e   op_cls;
  alu_op_e     alu_op;
  logic [7:0]  alu_a;
  logic [7:0]  alu_b;
  logic [7:0]  alu_res;
  logic        alu_c;
  logic        alu_v;
  logic        alu_n;
  logic        alu_z;
  logic        taken;

  function automatic op_class_e class_of(input logic [7:0] op);
    case (op[7:4])
      4'h1:    class_of = CLS_IMM;
      4'h2:    class_of = CLS_BRANCH;
      4'h3:    class_of = CLS_ABS;
      default: class_of = CLS_IMPLIED;
    endcase
  endfunction

  // ==========================================================
  // arithmetic unit
  alu_unit u_alu (
    .op        (alu_op),
    .a         (alu_a),
    .b         (alu_b),
    .carry_in  (p_q.c),
    .decimal   (p_q.d),
    .result    (alu_res),
    .carry_out (alu_c),
    .overflow  (alu_v),
    .negative  (alu_n),
    .zero      (alu_z)
  );

  // ==========================================================
  // operand routing
  always_comb begin
    op_now = (state_q == ST_FETCH) ? mem_rdata : opcode_q;
    op_cls = class_of(op_now);
    alu_op = ALU_PASS;
    alu_a  = a_q;
    alu_b  = mem_rdata;
    case (op_now)
      OPC_X_INCREMENT: begin
        alu_op = ALU_INC;
        alu_a  = x_q;
      end
      OPC_X_DECREMENT: begin
        alu_op = ALU_DEC;
        alu_a  = x_q;
      end
      OPC_Y_INCREMENT: begin
        alu_op = ALU_INC;
        alu_a  = y_q;
      end
      OPC_Y_DECREMENT: begin
        alu_op = ALU_DEC;
        alu_a  = y_q;
      end
      OPC_SHIFT_LEFT_ACC:      alu_op = ALU_ASL;
      OPC_ADD_CARRY_IMM:       alu_op = ALU_ADD;
      OPC_SUB_BORROW_IMM:      alu_op = ALU_SUB;
      OPC_AND_IMM:             alu_op = ALU_AND;
      OPC_BIT_TEST_IMM:        alu_op = ALU_BIT;
      OPC_COMPARE_ACCUMULATOR: alu_op = ALU_CMP;
      OPC_COMPARE_X_INDEX: begin
        alu_op = ALU_CMP;
        alu_a  = x_q;
      end
      OPC_COMPARE_Y_INDEX: begin
        alu_op = ALU_CMP;
        alu_a  = y_q;
      end
      OPC_MEMORY_INCREMENT: begin
        alu_op = ALU_INC;
        alu_a  = mem_rdata;
      end
      OPC_MEMORY_DECREMENT: begin
        alu_op = ALU_DEC;
        alu_a  = mem_rdata;
      end
      OPC_SHIFT_LEFT_MEM: begin
        alu_op = ALU_ASL;
        alu_a  = mem_rdata;
      end
      default: alu_op = ALU_PASS;
    endcase
  end

  // ==========================================================
  // branch conditions
  always_comb begin
    case (opcode_q)
      OPC_BRANCH_CARRY_CLEAR:    taken = (p_q.c == 1'b0);  // see [RULE4]
      OPC_BRANCH_CARRY_SET:      taken = (p_q.c == 1'b1);  // see [RULE5]
      OPC_BRANCH_ZERO_SET:       taken = (p_q.z == 1'b1);  // see [RULE6]
      OPC_BRANCH_ZERO_CLEAR:     taken = (p_q.z == 1'b0);  // see [RULE7]
      OPC_BRANCH_OVERFLOW_CLEAR: taken = (p_q.v == 1'b0);  // see [RULE8]
      OPC_BRANCH_OVERFLOW_SET:   taken = (p_q.v == 1'b1);  // see [RULE8]
      default:                   taken = 1'b0;
    endcase
  end

  // ==========================================================
  // sequencer and register updates
  always_comb begin
    phase_d   = ~phase_q;                                  // see [RULE1]
    state_d   = state_q;
    pc_d      = pc_q;
    a_d       = a_q;
    x_d       = x_q;
    y_d       = y_q;
    sp_d      = sp_q;
    p_d       = p_q;
    opcode_d  = opcode_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    result_d  = result_q;
    // architectural state moves only on the second clock of a core cycle
    if (phase_q) begin                                     // see [RULE1]
      case (state_q)
        ST_FETCH: begin
          opcode_d = mem_rdata;
          pc_d     = pc_q + 16'h0001;
          if (op_cls == CLS_IMPLIED) begin
            case (mem_rdata)
              OPC_CLEAR_IRQ_DISABLE: p_d.i = 1'b0;         // see [RULE16]
              OPC_SET_IRQ_DISABLE:   p_d.i = 1'b1;
              OPC_CLEAR_CARRY:       p_d.c = 1'b0;
              OPC_SET_CARRY:         p_d.c = 1'b1;
              OPC_CLEAR_DECIMAL:     p_d.d = 1'b0;
              OPC_SET_DECIMAL:       p_d.d = 1'b1;
              OPC_CLEAR_OVERFLOW:    p_d.v = 1'b0;
              OPC_X_INCREMENT, OPC_X_DECREMENT: begin
                x_d   = alu_res;                           // see [RULE14] [RULE15]
                p_d.n = alu_n;
                p_d.z = alu_z;
              end
              OPC_Y_INCREMENT, OPC_Y_DECREMENT: begin
                y_d   = alu_res;                           // see [RULE14] [RULE15]
                p_d.n = alu_n;
                p_d.z = alu_z;
              end
              OPC_SHIFT_LEFT_ACC: begin
                a_d   = alu_res;                           // see [RULE19]
                p_d.c = alu_c;
                p_d.n = alu_n;
                p_d.z = alu_z;
              end
              default: p_d = p_q;
            endcase
          end else begin
            state_d = ST_OPND;
          end
        end
        ST_OPND: begin
          addr_lo_d = mem_rdata;
          pc_d      = pc_q + 16'h0001;
          state_d   = ST_FETCH;
          case (class_of(opcode_q))
            CLS_IMM: begin
              case (opcode_q)
                OPC_ADD_CARRY_IMM, OPC_SUB_BORROW_IMM: begin
                  a_d   = alu_res;                         // see [RULE2] [RULE17]
                  p_d.c = alu_c;
                  p_d.v = alu_v;
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                OPC_BIT_TEST_IMM: begin
                  p_d.v = alu_v;                           // see [RULE18]
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                // compares leave the register itself untouched
                OPC_COMPARE_ACCUMULATOR, OPC_COMPARE_X_INDEX, OPC_COMPARE_Y_INDEX: begin
                  p_d.c = alu_c;                           // see [RULE9] [RULE10] [RULE11]
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                OPC_AND_IMM, OPC_LOAD_ACC_IMM: begin
                  a_d   = alu_res;
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                OPC_LOAD_X_IMM: begin
                  x_d   = alu_res;
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                OPC_LOAD_Y_IMM: begin
                  y_d   = alu_res;
                  p_d.n = alu_n;
                  p_d.z = alu_z;
                end
                OPC_LOAD_STACK_IMM: sp_d = mem_rdata;      // see [RULE3]
                default:            p_d  = p_q;
              endcase
            end
            CLS_BRANCH: begin
              // offset is relative to the byte after the operand
              if (taken) begin
                pc_d = pc_q + 16'h0001 + {{8{mem_rdata[7]}}, mem_rdata};
              end
            end
            default: state_d = ST_ADDR_HI;
          endcase
        end
        ST_ADDR_HI: begin
          addr_hi_d = mem_rdata;
          pc_d      = pc_q + 16'h0001;
          if (opcode_q == OPC_STORE_ACC) begin
            result_d = a_q;
            state_d  = ST_MEM_WRITE;
          end else if (opcode_q == OPC_MEMORY_INCREMENT || opcode_q == OPC_MEMORY_DECREMENT ||
                       opcode_q == OPC_SHIFT_LEFT_MEM) begin
            state_d = ST_MEM_READ;
          end else begin
            state_d = ST_FETCH;
          end
        end
        ST_MEM_READ: begin
          result_d = alu_res;                              // see [RULE12] [RULE13]
          p_d.n    = alu_n;
          p_d.z    = alu_z;
          if (opcode_q == OPC_SHIFT_LEFT_MEM) begin
            p_d.c = alu_c;                                 // see [RULE19]
          end
          state_d = ST_MEM_WRITE;
        end
        ST_MEM_WRITE: state_d = ST_FETCH;
        default:      state_d = ST_FETCH;
      endcase
    end
  end

  // ==========================================================
  // bus request, launched on the first clock of each core cycle
  always_comb begin
    bus_d       = bus_q;
    bus_d.rd    = 1'b0;
    bus_d.wr    = 1'b0;
    if (!phase_q) begin
      bus_d.wdata = result_q;
      case (state_q)
        ST_MEM_READ: begin
          bus_d.addr = {addr_hi_q, addr_lo_q};
          bus_d.rd   = 1'b1;
        end
        ST_MEM_WRITE: begin
          bus_d.addr = {addr_hi_q, addr_lo_q};             // see [RULE12] [RULE13]
          bus_d.wr   = 1'b1;
        end
        default: begin
          bus_d.addr = pc_q;
          bus_d.rd   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_FETCH;
      phase_q   <= 1'b0;
      pc_q      <= RESET_ADDR;
      a_q       <= 8'h00;
      x_q       <= 8'h00;
      y_q       <= 8'h00;
      sp_q      <= RESET_SP;
      p_q       <= '{n: 1'b0, v: 1'b0, d: 1'b0, i: 1'b1, z: 1'b0, c: 1'b0};
      opcode_q  <= 8'h00;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      result_q  <= 8'h00;
      bus_q     <= '0;
    end else begin
      state_q   <= state_d;
      phase_q   <= phase_d;
      pc_q      <= pc_d;
      a_q       <= a_d;
      x_q       <= x_d;
      y_q       <= y_d;
      sp_q      <= sp_d;
      p_q       <= p_d;
      opcode_q  <= opcode_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      result_q  <= result_d;
      bus_q     <= bus_d;
    end
  end

  // ==========================================================
  // outputs
  assign mem_req    = bus_q;
  assign core_view  = '{pc: pc_q, a: a_q, x: x_q, y: y_q, sp: sp_q, p: p_q};
  assign irq_enable = ~p_q.i;                              // see [RULE16]
  assign cycle_end  = phase_q;

endmodule
`default_nettype wire

// >>> pkg/core_pkg.sv
// Notes on behaviour
// [RULE1] core steps once per two system clocks
// [RULE2] add and subtract honour the decimal flag
// [RULE3] stack pointer loads from an immediate operand
// [RULE4] branch_carry_clear taken only when carry is 0
// [RULE5] branch_carry_set taken only when carry is 1
// [RULE6] branch_zero_set taken only when zero is 1
// [RULE7] branch_zero_clear taken only when zero is 0
// [RULE8] overflow branches follow overflow flag 0 / 1
// [RULE9] compare_accumulator sets flags, accumulator kept
// [RULE10] compare_x_index sets flags, x kept
// [RULE11] compare_y_index sets flags, y kept
// [RULE12] memory_decrement reads, subtracts one, writes back
// [RULE13] memory_increment reads, adds one, writes back
// [RULE14] x_decrement and y_decrement subtract one
// [RULE15] x_increment and y_increment add one
// [RULE16] clear_irq_disable writes interrupt disable to 0
// [RULE17] add with carry, carry from ninth bit
// [RULE18] bit test: zero from and, n v from operand
// [RULE19] shift_left_op: bit seven to carry, zero in
package core_pkg;

  // ==========================================================
  // timing and reset values
  localparam int          CORE_DIV     = 2;
  localparam int          SYS_CLK_HZ   = 20_000_000;
  localparam logic [15:0] RESET_PC     = 16'hA000;
  localparam logic [7:0]  RESET_SP     = 8'hFF;
  localparam logic [4:0]  BCD_LIMIT    = 5'h09;
  localparam logic [4:0]  BCD_FIX      = 5'h06;

  // ==========================================================
  // opcode encodings
  localparam logic [7:0] OPC_NOP                   = 8'h00;
  localparam logic [7:0] OPC_CLEAR_IRQ_DISABLE     = 8'h01;
  localparam logic [7:0] OPC_SET_IRQ_DISABLE       = 8'h02;
  localparam logic [7:0] OPC_CLEAR_CARRY           = 8'h03;
  localparam logic [7:0] OPC_SET_CARRY             = 8'h04;
  localparam logic [7:0] OPC_CLEAR_DECIMAL         = 8'h05;
  localparam logic [7:0] OPC_SET_DECIMAL           = 8'h06;
  localparam logic [7:0] OPC_CLEAR_OVERFLOW        = 8'h07;
  localparam logic [7:0] OPC_X_INCREMENT           = 8'h08;
  localparam logic [7:0] OPC_X_DECREMENT           = 8'h09;
  localparam logic [7:0] OPC_Y_INCREMENT           = 8'h0A;
  localparam logic [7:0] OPC_Y_DECREMENT           = 8'h0B;
  localparam logic [7:0] OPC_SHIFT_LEFT_ACC        = 8'h0C;
  localparam logic [7:0] OPC_ADD_CARRY_IMM         = 8'h10;
  localparam logic [7:0] OPC_SUB_BORROW_IMM        = 8'h11;
  localparam logic [7:0] OPC_AND_IMM               = 8'h12;
  localparam logic [7:0] OPC_BIT_TEST_IMM          = 8'h13;
  localparam logic [7:0] OPC_COMPARE_ACCUMULATOR   = 8'h14;
  localparam logic [7:0] OPC_COMPARE_X_INDEX       = 8'h15;
  localparam logic [7:0] OPC_COMPARE_Y_INDEX       = 8'h16;
  localparam logic [7:0] OPC_LOAD_ACC_IMM          = 8'h17;
  localparam logic [7:0] OPC_LOAD_X_IMM            = 8'h18;
  localparam logic [7:0] OPC_LOAD_Y_IMM            = 8'h19;
  localparam logic [7:0] OPC_LOAD_STACK_IMM        = 8'h1A;
  localparam logic [7:0] OPC_BRANCH_CARRY_CLEAR    = 8'h20;
  localparam logic [7:0] OPC_BRANCH_CARRY_SET      = 8'h21;
  localparam logic [7:0] OPC_BRANCH_ZERO_SET       = 8'h22;
  localparam logic [7:0] OPC_BRANCH_ZERO_CLEAR     = 8'h23;
  localparam logic [7:0] OPC_BRANCH_OVERFLOW_CLEAR = 8'h24;
  localparam logic [7:0] OPC_BRANCH_OVERFLOW_SET   = 8'h25;
  localparam logic [7:0] OPC_MEMORY_INCREMENT      = 8'h30;
  localparam logic [7:0] OPC_MEMORY_DECREMENT      = 8'h31;
  localparam logic [7:0] OPC_SHIFT_LEFT_MEM        = 8'h32;
  localparam logic [7:0] OPC_STORE_ACC             = 8'h33;

  // ==========================================================
  // types
  typedef enum logic [1:0] {CLS_IMPLIED, CLS_IMM, CLS_BRANCH, CLS_ABS} op_class_e;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_ADD, ALU_SUB, ALU_CMP, ALU_INC, ALU_DEC, ALU_ASL, ALU_AND, ALU_BIT
  } alu_op_e;

  typedef enum {ST_FETCH, ST_OPND, ST_ADDR_HI, ST_MEM_READ, ST_MEM_WRITE} core_state_e;

  typedef struct packed {
    logic n;
    logic v;
    logic d;
    logic i;
    logic z;
    logic c;
  } status_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mem_req_s;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  sp;
    status_s     p;
  } core_view_s;

endpackage

// >>> tb/cpu_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_core_checker
  import core_pkg::*;
(
  input wire logic       clock,      // system clock
  input wire logic       rst_n,      // reset, active low
  input wire logic [7:0] mem_rdata,  // read data
  input wire mem_req_s   mem_req,    // bus request
  input wire core_view_s core_view,  // programmer state
  input wire logic       irq_enable, // irqs accepted
  input wire logic       cycle_end   // core phase
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // opcode fetch: operand bytes may equal an opcode and sit at the pc,
  // so count the non-opcode accesses still due in each instruction
  logic [2:0] skip_q;
  logic       fetch;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      skip_q <= 3'h0;
    end else if (mem_req.rd || mem_req.wr) begin
      if (skip_q != 3'h0) begin
        skip_q <= skip_q - 3'h1;
      end else begin
        case (mem_rdata[7:4])
          4'h1, 4'h2: skip_q <= 3'h1;
          4'h3:       skip_q <= (mem_rdata[3:0] < 4'h3) ? 3'h4 : (mem_rdata[3:0] == 4'h3) ? 3'h3 : 3'h2;
          default:    skip_q <= 3'h0;
        endcase
      end
    end
  end
  assign fetch = mem_req.rd && (skip_q == 3'h0) && (mem_req.addr == core_view.pc);

  phase_rise_a: assert property (!cycle_end |=> cycle_end) else $error("phase stuck low");
  phase_fall_a: assert property (cycle_end |=> !cycle_end) else $error("phase stuck high");
  bus_phase_a: assert property ((mem_req.rd || mem_req.wr) |-> cycle_end) else $error("access off phase");
  state_hold_a: assert property (!cycle_end |=> $stable(core_view)) else $error("state moved");
  irq_mirror_a: assert property (irq_enable == !core_view.p.i) else $error("irq enable wrong");
  cli_clear_a: assert property (fetch && mem_rdata == OPC_CLEAR_IRQ_DISABLE |=> irq_enable)
    else $error("irqs still masked");
  x_inc_a: assert property (fetch && mem_rdata == OPC_X_INCREMENT |=>
    core_view.x == $past(core_view.x) + 8'h01) else $error("x not incremented");
  y_dec_a: assert property (fetch && mem_rdata == OPC_Y_DECREMENT |=>
    core_view.y == $past(core_view.y) - 8'h01) else $error("y not decremented");
  acc_keep_a: assert property (fetch && mem_rdata == OPC_COMPARE_ACCUMULATOR |=>
    $stable(core_view.a) [*3]) else $error("compare changed a");
  write_back_a: assert property (mem_req.wr |-> $past(mem_req.rd, 2) &&
    mem_req.addr == $past(mem_req.addr, 2)) else $error("write back elsewhere");
endmodule

bind cpu_core cpu_core_checker chk (.clock(clock), .rst_n(rst_n), .mem_rdata(mem_rdata), .mem_req(mem_req),
  .core_view(core_view), .irq_enable(irq_enable), .cycle_end(cycle_end));
`default_nettype wire

// >>> tb/cpu_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cpu_core_tb;
  import core_pkg::*;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] mem_rdata;
  mem_req_s   mem_req;
  core_view_s core_view;
  logic       irq_enable;
  logic       cycle_end;
  int         num_errors = 0;
  int         cmp_count = 0;

  always #25 clock = ~clock;

  cpu_core dut (.clock(clock), .rst_n(rst_n), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .core_view(core_view), .irq_enable(irq_enable), .cycle_end(cycle_end));
  mem_model mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // program area refilled with no-ops; data area left to the caller
  task automatic run(input logic [7:0] prog [$], input int clocks);
    @(negedge clock);
    rst_n = 1'b0;
    for (int i = 0; i < 64; i++) mem.mem[RESET_PC + i] = (i < prog.size()) ? prog[i] : 8'h00;
    @(negedge clock);
    rst_n = 1'b1;
    repeat (clocks) @(negedge clock);
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    int n;
    n = 0;
    chk("reset pc", RESET_PC, core_view.pc);
    chk("reset sp", RESET_SP, core_view.sp);
    chk("reset irq_enable", 1'b0, irq_enable);
    chk("reset rd", 1'b0, mem_req.rd);
    for (int i = 0; i < 64; i++) mem.mem[RESET_PC + i] = 8'h00;
    rst_n = 1'b1;
    repeat (20) begin
      @(negedge clock);
      n += mem_req.rd;
    end
    chk("fetches in 20 clocks", 16'h000A, n[15:0]);
    $display("done: reset and pacing");
  endtask

  task automatic t_branch;
    logic [7:0] sop [6] = '{8'h03, 8'h04, 8'h17, 8'h17, 8'h07, 8'h13};
    logic [7:0] sarg [6] = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h40};
    bit want [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] xe;
    for (int b = 0; b < 6; b++) begin
      for (int f = 0; f < 2; f++) begin
        run('{sop[b / 2 * 2 + f], sarg[b / 2 * 2 + f], 8'h20 + b[7:0], 8'h02, 8'h08, 8'h08, 8'h0A}, 40);
        xe = (f == want[b]) ? 8'h00 : 8'h02;
        chk("x after branch", xe, core_view.x);
        chk("y after branch", 8'h01, core_view.y);
      end
    end
    $display("done: branches");
  endtask

  task automatic t_compare;
    logic [7:0] rv [3] = '{8'h50, 8'h30, 8'h30};
    logic [7:0] mv [3] = '{8'h30, 8'h30, 8'h50};
    logic [7:0] d;
    logic [7:0] kept;
    logic [2:0] flags;
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 3; k++) begin
        d = rv[k] - mv[k];
        run('{8'h17 + r[7:0], rv[k], 8'h14 + r[7:0], mv[k]}, 20);
        kept  = (r == 0) ? core_view.a : (r == 1) ? core_view.x : core_view.y;
        flags = {core_view.p.n, core_view.p.z, core_view.p.c};
        chk("register kept", rv[k], kept);
        chk("compare nzc", {d[7], d == 8'h00, rv[k] >= mv[k]}, flags);
      end
    end
    $display("done: compares");
  endtask

  task automatic t_index;
    run('{8'h18, 8'hFF, 8'h08, 8'h19, 8'h00, 8'h0B}, 20);
    chk("x wraps up", 8'h00, core_view.x);
    chk("y wraps down", 8'hFF, core_view.y);
    run('{8'h18, 8'h00, 8'h09, 8'h19, 8'h7F, 8'h0A}, 20);
    chk("x wraps down", 8'hFF, core_view.x);
    chk("y to sign", 8'h80, core_view.y);
    $display("done: index steps");
  endtask

  task automatic t_memory;
    mem.mem[16'h0040] = 8'hFF;
    mem.mem[16'h0041] = 8'h00;
    mem.mem[16'h0042] = 8'h81;
    run('{8'h30, 8'h40, 8'h00, 8'h31, 8'h41, 8'h00, 8'h32, 8'h42, 8'h00}, 40);
    chk("incremented byte", 8'h00, mem.mem[16'h0040]);
    chk("decremented byte", 8'hFF, mem.mem[16'h0041]);
    chk("shifted byte", 8'h02, mem.mem[16'h0042]);
    chk("shift nzc", 3'b001, {core_view.p.n, core_view.p.z, core_view.p.c});
    $display("done: memory updates");
  endtask

  task automatic t_misc;
    run('{8'h01, 8'h1A, 8'h3C, 8'h17, 8'h0F, 8'h13, 8'hF0, 8'h0C}, 24);
    chk("irq_enable", 1'b1, irq_enable);
    chk("stack pointer", 8'h3C, core_view.sp);
    chk("bit test v", 1'b1, core_view.p.v);
    chk("shifted acc", 8'h1E, core_view.a);
    run('{8'h01, 8'h17, 8'h0F, 8'h13, 8'hF0}, 16);
    chk("bit test nz", 2'b11, {core_view.p.n, core_view.p.z});
    run('{8'h05, 8'h03, 8'h17, 8'h80, 8'h10, 8'h90}, 20);
    chk("binary sum", 8'h10, core_view.a);
    chk("binary vc", 2'b11, {core_view.p.v, core_view.p.c});
    run('{8'h06, 8'h03, 8'h17, 8'h58, 8'h10, 8'h46}, 20);
    chk("decimal sum", 8'h04, core_view.a);
    chk("decimal carry", 1'b1, core_view.p.c);
    run('{8'h06, 8'h04, 8'h17, 8'h42, 8'h11, 8'h15}, 20);
    chk("decimal difference", 8'h27, core_view.a);
    chk("decimal no borrow", 1'b1, core_view.p.c);
    $display("done: flags, stack, arithmetic");
  endtask

  // ==========================================================
  // sequence and watchdog
  initial begin
    repeat (12) @(negedge clock);
    t_reset();
    t_branch();
    t_compare();
    t_index();
    t_memory();
    t_misc();
    close_out();
  end

  initial begin
    #(50 * 5000);
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire

// >>> tb/mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_model
  import core_pkg::*;
(
  input  wire logic     clock,    // system clock
  input  wire mem_req_s mem_req,  // core request
  output logic    [7:0] mem_rdata // read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // released bus shows the inverse, so a stale byte never matches
  always_comb mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;
  always @(posedge clock) begin
    if (mem_req.rd) last_q <= mem[mem_req.addr];
    if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule
`default_nettype wire
